// [hdl/flash_status_cfg.svh]
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// opcodes
`define OP_READ_STATUS   8'h05
`define OP_WRITE_STATUS  8'h01
`define OP_WRITE_STATUS2 8'h31
`define OP_WRITE_ENABLE  8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_PAGE_PROGRAM  8'h02
`define OP_OTP_PROGRAM   8'h9B
`define OP_ERASE_4K      8'h20
`define OP_ERASE_32K     8'h52
`define OP_CHIP_ERASE    8'h60
`define OP_SW_RESET      8'hF0

// status byte one fields
`define S1_LOCK_BIT    7
`define S1_ERROR_BIT   5
`define S1_PIN_BIT     4
`define S1_PROTECT_BIT 2
`define S1_LATCH_BIT   1
`define S_BUSY_BIT     0
// status byte two fields
`define S2_RST_EN_BIT  4

// counts and reset values
`define BIT_LAST     3'h7
`define BIT_FIRST    3'h0
`define RD_FIRST     4'h0
`define RD_STEP      4'h1
`define BIT_STEP     3'h1
`define BYTE_ZERO    8'h00
`define WORD_ZERO    16'h0000
`define RD_SECOND    4'h8
`define RD_LAST      4'hF

// idle levels of synchronised pins {cs_n, sck, si, wp_n} and of {cs_n, sck}
`define PIN_IDLE     4'h9
`define EDGE_IDLE    2'h2

`endif

// [hdl/flash_status_pkg.sv]
`default_nettype none
package flash_status_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] status_word_t;
  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_DATA   = 2'b01,
    PH_EXTRA  = 2'b10
  } spi_phase_t;
endpackage
`default_nettype wire

// [hdl/pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for asynchronous pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // pins and synchronised copies
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] reset_level,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [1:0]       fill_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      fill_reg   <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      fill_reg   <= {fill_reg[0], 1'b1};
    end
  end

  // idle level until the chain has filled
  assign pin_sync_out = fill_reg[1] ? stage2_reg : reset_level;
endmodule
`default_nettype wire

// [hdl/edge_detect.sv]
`timescale 1ns/100ps
`default_nettype none
// rise and fall pulses of synchronised levels
module edge_detect #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // level in, one-cycle pulses out
  input  wire logic [WIDTH-1:0] level_in,
  input  wire logic [WIDTH-1:0] reset_level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] last_reg;
  logic             primed_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_reg   <= '0;
      primed_reg <= 1'b0;
    end else begin
      last_reg   <= level_in;
      primed_reg <= 1'b1;
    end
  end

  wire [WIDTH-1:0] last_level = primed_reg ? last_reg : reset_level;
  assign rise = level_in & ~last_level;
  assign fall = ~level_in & last_level;
endmodule
`default_nettype wire

// [hdl/flash_status_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_cfg.svh"

// Notes on behaviour
// - status readable anytime, even while busy
// - status is two bytes, both read
// - opcode 05h then status on every clock
// - byte one msb first, then byte two, repeat
// - live status sampled each repetition
// - chip select high ends read, output off
// - lock and wp asserted freeze array protect
// - protection lock clears at power-up
// - wp asserted: lock may only rise
// - write status alters only bits 7, 2
// - error flag set on failed program/erase
// - protection aborts leave error flag alone
// - byte one bit 4 mirrors wp pin
// - array protect rejects program and erase
// - clear latch refuses write commands
// - qualifying command end clears enable latch
// - partial opcode abort keeps enable latch
// - busy bit in both bytes while running
// - reset enable gates software reset
// - software reset keeps reset enable
// - 01h data carries lock and protect
// - 31h data bit 4 carries reset enable
module flash_status_regs (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // spi pins
  input  wire logic                   cs_n,
  input  wire logic                   sck,
  input  wire logic                   si,
  output logic                        so,
  output logic                        so_oe,
  // write protect pin
  input  wire logic                   wp_n,
  // program and erase engine
  input  wire logic                   engine_busy,
  input  wire logic                   op_end,
  input  wire logic                   op_fail,
  input  wire logic                   hold_abort,
  output logic                        prog_req,
  output flash_status_pkg::byte_t     prog_opcode,
  output logic                        sw_reset
);
  import flash_status_pkg::*;

  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       wp_n_s;
  logic [1:0] rise_pulse;
  logic [1:0] fall_pulse;

  pin_sync #(.WIDTH(4)) u_sync (
    .clk          (clk),
    .resetn       (resetn),
    .pin_in       ({cs_n, sck, si, wp_n}),
    .reset_level  (`PIN_IDLE),
    .pin_sync_out ({cs_n_s, sck_s, si_s, wp_n_s})
  );

  edge_detect #(.WIDTH(2)) u_edge (
    .clk         (clk),
    .resetn      (resetn),
    .level_in    ({cs_n_s, sck_s}),
    .reset_level (`EDGE_IDLE),
    .rise        (rise_pulse),
    .fall        (fall_pulse)
  );

  // state
  spi_phase_t   phase_reg;
  logic [2:0]   bit_cnt_reg;
  byte_t        shift_reg;
  byte_t        opcode_reg;
  byte_t        data_reg;
  logic [3:0]   rd_cnt_reg;
  status_word_t snap_reg;
  logic         so_reg;
  logic         so_oe_reg;
  logic         lock_reg;
  logic         protect_reg;
  logic         err_reg;
  logic         latch_reg;
  logic         reset_en_reg;
  logic         prog_req_reg;
  byte_t        prog_opcode_reg;
  logic         sw_reset_reg;

  // decode
  wire   cs_active  = ~cs_n_s;
  wire   cs_end     = rise_pulse[1];
  wire   sck_rise   = rise_pulse[0] & cs_active;
  wire   sck_fall   = fall_pulse[0] & cs_active;
  wire   wp_active  = ~wp_n_s;
  byte_t shift_next;
  assign shift_next = {shift_reg[6:0], si_s};
  wire   byte_done  = sck_rise & (bit_cnt_reg == `BIT_LAST);
  wire   have_op    = phase_reg != PH_OPCODE;
  wire   have_data  = phase_reg == PH_EXTRA;
  wire   whole      = bit_cnt_reg == `BIT_FIRST;
  wire   reading    = have_op & (opcode_reg == `OP_READ_STATUS) & cs_active;
  wire   is_ws      = opcode_reg == `OP_WRITE_STATUS;
  wire   is_ws2     = opcode_reg == `OP_WRITE_STATUS2;
  wire   is_wren    = opcode_reg == `OP_WRITE_ENABLE;
  wire   is_wrdi    = opcode_reg == `OP_WRITE_DISABLE;
  wire   is_rst     = opcode_reg == `OP_SW_RESET;
  wire   is_prog    = (opcode_reg == `OP_PAGE_PROGRAM) | (opcode_reg == `OP_OTP_PROGRAM)
                    | (opcode_reg == `OP_ERASE_4K) | (opcode_reg == `OP_ERASE_32K)
                    | (opcode_reg == `OP_CHIP_ERASE);
  wire   qualifying = is_ws | is_ws2 | is_prog;
  // write status with its full data byte and the latch set
  wire   ws_valid   = cs_end & have_data & whole & latch_reg & ~engine_busy;
  wire   lock_drop  = wp_active & lock_reg & ~data_reg[`S1_LOCK_BIT];
  wire   ws_take    = ws_valid & is_ws & ~lock_drop;
  wire   ws2_take   = ws_valid & is_ws2;
  wire   bp_frozen  = lock_reg & wp_active;
  wire   latch_clr  = (cs_end & have_op & (qualifying | is_wrdi)) | hold_abort
                    | sw_reset_reg;
  wire   latch_set  = cs_end & have_op & ~have_data & whole & is_wren;
  wire   prog_go    = cs_end & have_op & whole & is_prog & latch_reg & ~protect_reg
                    & ~engine_busy;
  wire   rst_go     = cs_end & have_op & whole & is_rst & reset_en_reg;

  // live status, reserved bits zero
  byte_t        status_one;
  byte_t        status_two;
  status_word_t live_word;
  always_comb begin
    status_one                  = `BYTE_ZERO;
    status_two                  = `BYTE_ZERO;
    status_one[`S1_LOCK_BIT]    = lock_reg;
    status_one[`S1_ERROR_BIT]   = err_reg;
    status_one[`S1_PIN_BIT]     = wp_n_s;
    status_one[`S1_PROTECT_BIT] = protect_reg;
    status_one[`S1_LATCH_BIT]   = latch_reg;
    status_one[`S_BUSY_BIT]     = engine_busy;
    status_two[`S2_RST_EN_BIT]  = reset_en_reg;
    status_two[`S_BUSY_BIT]     = engine_busy;
  end
  assign live_word = {status_one, status_two};

  // readout word: fresh sample at the start of each repetition
  wire          rd_start = rd_cnt_reg == `RD_FIRST;
  status_word_t rd_word;
  assign rd_word = rd_start ? live_word : snap_reg;
  wire   [3:0]  rd_index = `RD_LAST - rd_cnt_reg;

  // command framing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg   <= PH_OPCODE;
      bit_cnt_reg <= `BIT_FIRST;
      shift_reg   <= `BYTE_ZERO;
      opcode_reg  <= `BYTE_ZERO;
      data_reg    <= `BYTE_ZERO;
    end else if (!cs_active) begin
      phase_reg   <= PH_OPCODE;
      bit_cnt_reg <= `BIT_FIRST;
    end else if (sck_rise) begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + `BIT_STEP;
      if (byte_done) begin
        unique case (phase_reg)
          PH_OPCODE: begin
            opcode_reg <= shift_next;
            phase_reg  <= PH_DATA;
          end
          PH_DATA: begin
            data_reg  <= shift_next;
            phase_reg <= PH_EXTRA;
          end
          PH_EXTRA: begin
            phase_reg <= PH_EXTRA;
          end
          default: begin
            phase_reg <= PH_OPCODE;
          end
        endcase
      end
    end
  end

  // status shift-out on falling sck
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_cnt_reg <= `RD_FIRST;
      snap_reg   <= `WORD_ZERO;
      so_reg     <= 1'b0;
      so_oe_reg  <= 1'b0;
    end else if (!reading) begin
      rd_cnt_reg <= `RD_FIRST;
      so_oe_reg  <= 1'b0;
    end else if (sck_fall) begin
      snap_reg   <= rd_word;
      so_reg     <= rd_word[rd_index];
      so_oe_reg  <= 1'b1;
      rd_cnt_reg <= rd_cnt_reg + `RD_STEP;
    end
  end

  // protection bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_reg    <= 1'b0;
      protect_reg <= 1'b0;
    end else if (ws_take) begin
      lock_reg    <= data_reg[`S1_LOCK_BIT];
      protect_reg <= bp_frozen ? protect_reg : data_reg[`S1_PROTECT_BIT];
    end
  end

  // error flag updated only by the engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_reg <= 1'b0;
    end else if (op_end) begin
      err_reg <= op_fail;
    end
  end

  // enable latch; set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= 1'b0;
    end else if (latch_set) begin
      latch_reg <= 1'b1;
    end else if (latch_clr) begin
      latch_reg <= 1'b0;
    end
  end

  // reset enable, untouched by software reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_en_reg <= 1'b0;
    end else if (ws2_take) begin
      reset_en_reg <= data_reg[`S2_RST_EN_BIT];
    end
  end

  // engine requests
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_req_reg    <= 1'b0;
      prog_opcode_reg <= `BYTE_ZERO;
      sw_reset_reg    <= 1'b0;
    end else begin
      prog_req_reg    <= prog_go;
      sw_reset_reg    <= rst_go;
      if (prog_go) begin
        prog_opcode_reg <= opcode_reg;
      end
    end
  end

  assign so          = so_reg;
  assign so_oe       = so_oe_reg;
  assign prog_req    = prog_req_reg;
  assign prog_opcode = prog_opcode_reg;
  assign sw_reset    = sw_reset_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_so_off_idle: assert property (cs_n_s |=> !so_oe)
    else $error("serial output driven with chip select high");
  a_read_order: assert property (sck_fall && reading && rd_cnt_reg == `RD_SECOND
    |=> so == $past(snap_reg[7]))
    else $error("byte two bit 7 not after byte one");
  a_read_sample: assert property (sck_fall && reading && rd_start
    |=> snap_reg == $past(live_word))
    else $error("status not resampled at repetition start");
  a_pin_mirror: assert property (status_one[`S1_PIN_BIT] == $past(wp_n, 2))
    else $error("wp mirror bit wrong");
  a_lock_no_fall: assert property (wp_active && lock_reg && !$changed(wp_n_s)
    |=> lock_reg)
    else $error("lock cleared while wp asserted");
  a_protect_frozen: assert property (wp_active && lock_reg |=> $stable(protect_reg))
    else $error("array protect changed while locked");
  a_err_update: assert property (op_end |=> err_reg == $past(op_fail))
    else $error("error flag not updated at operation end");
  a_latch_clear_ws: assert property (cs_end && have_op && qualifying && !latch_set
    |=> !latch_reg)
    else $error("enable latch kept after qualifying command");
  a_latch_keep_part: assert property (cs_end && !have_op && latch_reg && !hold_abort
    && !sw_reset_reg |=> latch_reg)
    else $error("enable latch lost on partial opcode");
  a_prog_gate: assert property (prog_req |-> $past(latch_reg && !protect_reg))
    else $error("program issued while refused");
  a_reset_gate: assert property (sw_reset |-> $past(reset_en_reg))
    else $error("software reset with reset disabled");
  a_reset_en_kept: assert property (sw_reset |-> $stable(reset_en_reg))
    else $error("software reset changed reset enable");

  c_read_repeat: cover property (sck_fall && reading && rd_cnt_reg == `RD_LAST);
  c_write_status: cover property (ws_take);
  c_write_enable: cover property (latch_set);
  c_sw_reset: cover property (sw_reset);
endmodule
`default_nettype wire

// [dv/spi_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// spi mode 0 host, clock idle low between frames
module spi_host_model (
  // clock for the released-line model
  input  wire logic clk,
  // spi pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  import flash_status_pkg::*;
  logic so_last = 1'b0;
  logic so_line;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // a released line shows the inverse of the last driven bit
  always @(posedge clk) begin
    if (so_oe) so_last <= so;
  end
  assign so_line = so_oe ? so : ~so_last;

  // opcode then ndat data bits msb first, then nrd bits read back;
  // a negative ndat cuts the opcode short
  task automatic frame(input byte_t op, input byte_t dat, input int ndat, input int nrd,
                       output logic [31:0] rx);
    logic [15:0] tx;
    int          i;
    tx = {op, dat};
    rx = 32'h0000_0000;
    #3.3 cs_n = 1'b0;
    for (i = 0; i < 8 + ndat + nrd; i++) begin
      si = (i < 16) ? tx[15 - i] : ~si;
      #62.5 sck = 1'b1;
      if (i >= 8) rx = {rx[30:0], so_line};
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// [dv/spi_flash_status_register_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_cfg.svh"
module spi_flash_status_register_bench;
  import flash_status_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wp_n = 1'b1;
  logic        engine_busy = 1'b0;
  logic        op_end = 1'b0;
  logic        op_fail = 1'b0;
  logic        hold_abort = 1'b0;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        prog_req;
  logic        sw_reset;
  byte_t       prog_opcode;
  byte_t       req_op;
  logic [31:0] rx;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          req_cnt = 0;
  int          rst_cnt = 0;

  flash_status_regs u_flash_status_regs (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck),
    .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .engine_busy(engine_busy), .op_end(op_end),
    .op_fail(op_fail), .hold_abort(hold_abort), .prog_req(prog_req),
    .prog_opcode(prog_opcode), .sw_reset(sw_reset));
  spi_host_model u_spi_host_model (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe(so_oe));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (prog_req) req_cnt++;
    if (prog_req) req_op = prog_opcode;
    if (sw_reset) rst_cnt++;
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check_byte(input byte_t got, input byte_t exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cmd(input byte_t op, input byte_t dat, input int ndat);
    u_spi_host_model.frame(op, dat, ndat, 0, rx);
  endtask

  task automatic wr_status(input byte_t dat);
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    cmd(8'h01, dat, 8);
  endtask

  task automatic read_status(input byte_t b1, input byte_t b2);
    u_spi_host_model.frame(8'h05, 8'h00, 0, 32, rx);
    check_byte(rx[31:24], b1);
    check_byte(rx[23:16], b2);
    check_byte(rx[15:8], b1);
    check_byte(rx[7:0], b2);
    check_bit(so_oe, 1'b0);
  endtask

  task automatic set_in(ref logic sig, input logic v);
    @(posedge clk);
    #1 sig = v;
    repeat (4) @(posedge clk);
  endtask

  task automatic pulse(ref logic sig);
    @(posedge clk);
    #1 sig = 1'b1;
    @(posedge clk);
    #1 sig = 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_power_up();
    read_status(8'h10, 8'h00);
    u_spi_host_model.frame(8'h05, 8'h00, 0, 5, rx);
    check_byte(rx[7:0], 8'h02);
    check_bit(so_oe, 1'b0);
  endtask

  task automatic t_latch();
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    read_status(8'h12, 8'h00);
    cmd(`OP_PAGE_PROGRAM, 8'h00, -4);
    read_status(8'h12, 8'h00);
    cmd(`OP_WRITE_DISABLE, 8'h00, 0);
    read_status(8'h10, 8'h00);
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    pulse(hold_abort);
    read_status(8'h10, 8'h00);
  endtask

  task automatic t_write_status();
    cmd(8'h01, 8'hFF, 8);
    read_status(8'h10, 8'h00);
    wr_status(8'hFF);
    read_status(8'h94, 8'h00);
    set_in(wp_n, 1'b0);
    read_status(8'h84, 8'h00);
    wr_status(8'h00);
    read_status(8'h84, 8'h00);
    wr_status(8'h80);
    read_status(8'h84, 8'h00);
    set_in(wp_n, 1'b1);
    wr_status(8'h00);
    read_status(8'h10, 8'h00);
    cmd(8'h01, 8'hFF, 8);
    read_status(8'h10, 8'h00);
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    cmd(8'h01, 8'hFF, 4);
    read_status(8'h10, 8'h00);
  endtask

  task automatic t_program();
    byte_t ops[5];
    int    i;
    int    n;
    ops = '{`OP_PAGE_PROGRAM, `OP_OTP_PROGRAM, `OP_ERASE_4K, `OP_ERASE_32K, `OP_CHIP_ERASE};
    for (i = 0; i < 5; i++) begin
      n = req_cnt;
      wr_status(8'h00);
      cmd(`OP_WRITE_ENABLE, 8'h00, 0);
      cmd(ops[i], 8'h00, 8);
      check_byte(8'(req_cnt - n), 8'h01);
      check_byte(req_op, ops[i]);
      read_status(8'h10, 8'h00);
    end
    n = req_cnt;
    cmd(`OP_PAGE_PROGRAM, 8'h00, 8);
    check_byte(8'(req_cnt - n), 8'h00);
    wr_status(8'h04);
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    cmd(`OP_ERASE_4K, 8'h00, 8);
    check_byte(8'(req_cnt - n), 8'h00);
    read_status(8'h14, 8'h00);
    wr_status(8'h00);
  endtask

  task automatic t_engine();
    set_in(engine_busy, 1'b1);
    read_status(8'h11, 8'h01);
    fork
      u_spi_host_model.frame(8'h05, 8'h00, 0, 32, rx);
      begin
        #2000;
        set_in(engine_busy, 1'b0);
      end
    join
    check_byte(rx[31:24], 8'h11);
    check_byte(rx[23:16], 8'h01);
    check_byte(rx[15:8], 8'h10);
    check_byte(rx[7:0], 8'h00);
    set_in(op_fail, 1'b1);
    pulse(op_end);
    read_status(8'h30, 8'h00);
    set_in(op_fail, 1'b0);
    pulse(op_end);
    read_status(8'h10, 8'h00);
  endtask

  task automatic t_reset_cmd();
    int n;
    n = rst_cnt;
    cmd(`OP_SW_RESET, 8'h00, 0);
    check_byte(8'(rst_cnt - n), 8'h00);
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    cmd(8'h31, 8'hFF, 8);
    read_status(8'h10, 8'h10);
    cmd(`OP_SW_RESET, 8'h00, 0);
    check_byte(8'(rst_cnt - n), 8'h01);
    read_status(8'h10, 8'h10);
    cmd(`OP_WRITE_ENABLE, 8'h00, 0);
    cmd(8'h31, 8'hEF, 8);
    read_status(8'h10, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk);
    t_power_up();
    t_latch();
    t_write_status();
    t_program();
    t_engine();
    t_reset_cmd();
    end_sim();
  end
endmodule
`default_nettype wire
